/* modem_cfg_pkg.sv */
// Constants for the modem rate and format configuration block.
// Assumes the byte-wide register port of the host serial interface.
package modem_cfg_pkg;
   localparam logic [7:0] ADDR_BW_RATE = 8'h10;
   localparam logic [7:0] ADDR_MANTISSA = 8'h11;
   localparam logic [7:0] ADDR_FORMAT = 8'h12;
   localparam logic [7:0] RST_BW_RATE = 8'h8C;
   localparam logic [7:0] RST_MANTISSA = 8'h22;
   localparam logic [7:0] RST_FORMAT = 8'h00;
   localparam logic [7:0] FORMAT_MASK = 8'hF8;
   localparam logic [7:0] READ_NONE = 8'h00;
   localparam int EXP_LSB = 0;
   localparam int EXP_MSB = 3;
   localparam int BYPASS_BIT = 7;
   localparam int MOD_LSB = 4;
   localparam int MOD_MSB = 6;
   localparam int MANCH_BIT = 3;
   localparam int ACC_BITS = 28;
   localparam int INC_BITS = 24;
   localparam logic [8:0] HIDDEN_ONE = 9'h100;
   localparam logic [2:0] MOD_2FSK = 3'h0;
   localparam logic [2:0] MOD_GFSK = 3'h1;
   localparam logic [2:0] MOD_ASK = 3'h3;
   localparam logic [2:0] MOD_MSK = 3'h7;
   typedef enum logic [1:0] {
      PH_FIRST = 2'h1,
      PH_SECOND = 2'h2
   } phase_t;
endpackage

/* rate_if.sv */
// Carries the symbol-rate setting to the rate generator and its tick back.
// Assumes one clock domain shared by both ends.
interface rate_if;
   logic [7:0] mantissa;
   logic [3:0] exponent;
   logic tick;
   modport gen (input mantissa, input exponent, output tick);
   modport user (output mantissa, output exponent, input tick);
endinterface

/* symbol_rate_gen.sv */
// Phase-accumulator symbol-rate generator.
// Assumes clk_sys is the crystal clock; ce freezes the accumulator.
module symbol_rate_gen (
   // Clock and control
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   // Rate setting and tick
   rate_if.gen rate
);
   localparam int INC_BITS = modem_cfg_pkg::INC_BITS;
   localparam int ACC_BITS_W = modem_cfg_pkg::ACC_BITS;

   logic [modem_cfg_pkg::ACC_BITS-1:0] acc;
   logic [modem_cfg_pkg::ACC_BITS-1:0] next_acc;
   logic tick;
   logic next_tick;
   logic [modem_cfg_pkg::INC_BITS-1:0] inc;
   logic [modem_cfg_pkg::ACC_BITS:0] sum;

   // ------------------------------------------------------------
   // Accumulator
   // ------------------------------------------------------------
   always_comb begin
      inc = INC_BITS'({modem_cfg_pkg::HIDDEN_ONE[8], rate.mantissa}) << rate.exponent;
      sum = {1'b0, acc} + {5'h00, inc};
      next_acc = acc;
      next_tick = 1'b0;
      if (srst) begin
         next_acc = '0;
      end else if (ce) begin
         next_acc = sum[modem_cfg_pkg::ACC_BITS-1:0];
         next_tick = sum[modem_cfg_pkg::ACC_BITS];
      end else begin
         next_tick = tick;
      end
   end

   always_ff @(posedge clk_sys) begin
      acc <= next_acc;
      tick <= next_tick;
   end

   assign rate.tick = tick;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_acc_step: assert property (ce |=> acc == ($past(acc) + ACC_BITS_W'($past(inc))))
      else $error("Rate accumulator did not advance by the increment.");
   a_tick_carry: assert property (ce && (({1'b0, acc} + {5'h00, inc}) >> 28) != 0 |=> tick)
      else $error("Symbol tick missing on accumulator overflow.");
   a_hidden_bit: assert property (rate.exponent == 4'h0 |-> inc >= 24'h000100)
      else $error("Hidden mantissa bit not applied.");
endmodule // symbol_rate_gen

/* modem_rate_format_config.sv */
// Modem symbol-rate, modulation format and line-coding configuration.
// Assumes a decoded byte register port from the host serial interface.
// Functional notes
// - The mantissa register holds an 8-bit read/write value at bits 7:0, reset to 0x22.
// - The rate is a 9-bit mantissa with a hidden leading one and a 4-bit exponent.
// - The symbol rate is crystal times (256 plus mantissa) shifted by exponent over 2^28.
// - Bit 7 of the format register bypasses the DC-blocking filter when set, reset zero.
// - Bits 6:4 select 2-FSK, GFSK, ASK/OOK or MSK by codes 0, 1, 3 and 7, reset zero.
// - The exponent is a 4-bit read/write field in bits 3:0 at offset 0x10, reset twelve.
module modem_rate_format_config (
   // Clock and control
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Demodulator and format controls
   output logic dc_filter_enable,
   output logic mod_2fsk,
   output logic mod_gfsk,
   output logic mod_ask,
   output logic mod_msk,
   output logic mod_unassigned,
   // Transmit bit stream
   input wire logic tx_data,
   output logic tx_take,
   output logic tx_line,
   // Receive bit stream
   input wire logic rx_line,
   output logic rx_data,
   output logic rx_valid,
   output logic rx_code_error
);
   logic [7:0] bw_rate;
   logic [7:0] mantissa;
   logic [7:0] format;
   logic [7:0] next_bw_rate;
   logic [7:0] next_mantissa;
   logic [7:0] next_format;
   logic [7:0] next_reg_rdata;
   logic next_reg_rvalid;
   logic [2:0] mod_code;
   logic manch_en;
   logic tick;
   modem_cfg_pkg::phase_t phase;
   modem_cfg_pkg::phase_t next_phase;
   logic tx_held;
   logic next_tx_held;
   logic next_tx_line;
   logic rx_first;
   logic next_rx_first;
   logic next_rx_data;
   logic next_rx_valid;
   logic next_rx_code_error;
   logic [5:0] next_mod_flags;
   logic next_dc_filter_enable;

   rate_if rate ();

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_comb begin
      next_bw_rate = bw_rate;
      next_mantissa = mantissa;
      next_format = format;
      next_reg_rdata = reg_rdata;
      next_reg_rvalid = reg_rvalid;
      if (srst) begin
         next_bw_rate = modem_cfg_pkg::RST_BW_RATE;
         next_mantissa = modem_cfg_pkg::RST_MANTISSA;
         next_format = modem_cfg_pkg::RST_FORMAT;
         next_reg_rdata = modem_cfg_pkg::READ_NONE;
         next_reg_rvalid = 1'b0;
      end else if (ce) begin
         if (reg_wr) begin
            unique case (reg_addr)
               modem_cfg_pkg::ADDR_BW_RATE: next_bw_rate = reg_wdata;
               modem_cfg_pkg::ADDR_MANTISSA: next_mantissa = reg_wdata;
               modem_cfg_pkg::ADDR_FORMAT: next_format = reg_wdata & modem_cfg_pkg::FORMAT_MASK;
               default: next_format = format;
            endcase
         end
         next_reg_rvalid = reg_rd;
         unique case (reg_addr)
            modem_cfg_pkg::ADDR_BW_RATE: next_reg_rdata = bw_rate;
            modem_cfg_pkg::ADDR_MANTISSA: next_reg_rdata = mantissa;
            modem_cfg_pkg::ADDR_FORMAT: next_reg_rdata = format;
            default: next_reg_rdata = modem_cfg_pkg::READ_NONE;
         endcase
         if (!reg_rd) begin
            next_reg_rdata = reg_rdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      bw_rate <= next_bw_rate;
      mantissa <= next_mantissa;
      format <= next_format;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
   end

   // ------------------------------------------------------------
   // Format decode
   // ------------------------------------------------------------
   assign mod_code = format[modem_cfg_pkg::MOD_MSB:modem_cfg_pkg::MOD_LSB];
   assign manch_en = format[modem_cfg_pkg::MANCH_BIT];

   always_comb begin
      next_dc_filter_enable = ~format[modem_cfg_pkg::BYPASS_BIT];
      next_mod_flags = 6'h00;
      next_mod_flags[0] = (mod_code == modem_cfg_pkg::MOD_2FSK);
      next_mod_flags[1] = (mod_code == modem_cfg_pkg::MOD_GFSK);
      next_mod_flags[2] = (mod_code == modem_cfg_pkg::MOD_ASK);
      next_mod_flags[3] = (mod_code == modem_cfg_pkg::MOD_MSK);
      next_mod_flags[4] = ~|next_mod_flags[3:0];
      if (srst) begin
         next_dc_filter_enable = 1'b1;
         next_mod_flags = 6'h01;
      end else if (!ce) begin
         next_dc_filter_enable = dc_filter_enable;
         next_mod_flags = {1'b0, mod_unassigned, mod_msk, mod_ask, mod_gfsk, mod_2fsk};
      end
   end

   always_ff @(posedge clk_sys) begin
      dc_filter_enable <= next_dc_filter_enable;
      {mod_unassigned, mod_msk, mod_ask, mod_gfsk, mod_2fsk} <= next_mod_flags[4:0];
   end

   // ------------------------------------------------------------
   // Symbol rate
   // ------------------------------------------------------------
   assign rate.mantissa = mantissa;
   assign rate.exponent = bw_rate[modem_cfg_pkg::EXP_MSB:modem_cfg_pkg::EXP_LSB];
   assign tick = rate.tick;

   symbol_rate_gen u_rate (
      .clk_sys(clk_sys),
      .srst(srst),
      .ce(ce),
      .rate(rate)
   );

   // ------------------------------------------------------------
   // Line coding
   // ------------------------------------------------------------
   assign tx_take = ce && tick && !srst && (!manch_en || phase == modem_cfg_pkg::PH_FIRST);

   always_comb begin
      next_phase = phase;
      next_tx_held = tx_held;
      next_tx_line = tx_line;
      next_rx_first = rx_first;
      next_rx_data = rx_data;
      next_rx_valid = 1'b0;
      next_rx_code_error = rx_code_error;
      if (srst) begin
         next_phase = modem_cfg_pkg::PH_FIRST;
         next_tx_held = 1'b0;
         next_tx_line = 1'b0;
         next_rx_first = 1'b0;
         next_rx_data = 1'b0;
         next_rx_code_error = 1'b0;
      end else if (!ce) begin
         next_rx_valid = rx_valid;
      end else if (!manch_en) begin
         next_phase = modem_cfg_pkg::PH_FIRST;
         if (tick) begin
            next_tx_line = tx_data;
            next_rx_data = rx_line;
            next_rx_valid = 1'b1;
            next_rx_code_error = 1'b0;
         end
      end else if (tick) begin
         unique case (phase)
            modem_cfg_pkg::PH_FIRST: begin
               next_tx_held = tx_data;
               next_tx_line = tx_data;
               next_rx_first = rx_line;
               next_phase = modem_cfg_pkg::PH_SECOND;
            end
            modem_cfg_pkg::PH_SECOND: begin
               next_tx_line = ~tx_held;
               next_rx_data = rx_first;
               next_rx_code_error = (rx_first == rx_line);
               next_rx_valid = 1'b1;
               next_phase = modem_cfg_pkg::PH_FIRST;
            end
            default: next_phase = modem_cfg_pkg::PH_FIRST;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      phase <= next_phase;
      tx_held <= next_tx_held;
      tx_line <= next_tx_line;
      rx_first <= next_rx_first;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      rx_code_error <= next_rx_code_error;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking

   a_mant_reset: assert property (srst |=> mantissa == 8'h22)
      else $error("Mantissa reset value wrong.");
   a_mant_write: assert property (disable iff (srst)
      ce && reg_wr && reg_addr == 8'h11 |=> mantissa == $past(reg_wdata))
      else $error("Mantissa write not stored.");
   a_exp_reset: assert property (srst |=> rate.exponent == 4'hC)
      else $error("Exponent reset value wrong.");
   a_bypass_ctl: assert property (disable iff (srst)
      ce && reg_wr && reg_addr == 8'h12 ##1 ce |=> dc_filter_enable == !$past(reg_wdata[7], 2))
      else $error("DC filter bypass not applied.");
   a_msk_decode: assert property (disable iff (srst)
      ce && reg_wr && reg_addr == 8'h12 && reg_wdata[6:4] == 3'h7 ##1 ce
      |=> mod_msk && !mod_2fsk && !mod_unassigned)
      else $error("MSK code not decoded.");
   a_code_unused: assert property (disable iff (srst)
      ce && reg_wr && reg_addr == 8'h12 && reg_wdata[6:4] == 3'h2 ##1 ce
      |=> mod_unassigned && !mod_ask)
      else $error("Unassigned code not flagged.");
   sequence s_first_half;
      ce && manch_en && tick && phase == modem_cfg_pkg::PH_FIRST;
   endsequence
   sequence s_second_half;
      ce && manch_en && tick && phase == modem_cfg_pkg::PH_SECOND;
   endsequence
   a_manch_first: assert property (disable iff (srst)
      s_first_half |=> tx_line == $past(tx_data))
      else $error("Manchester first half does not carry the data bit.");
   a_manch_pair: assert property (disable iff (srst)
      s_second_half |=> tx_line != $past(tx_line))
      else $error("Manchester second half not inverted.");
endmodule // modem_rate_format_config

/* modem_rate_format_config_tb.sv */
// Self-checking testbench for the modem rate and format configuration block.
// Assumes the design files are compiled first; inputs change on the falling clock edge.
module modem_rate_format_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Stimulus signals
   // ----------------------------------------
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic tx_data = 1'b0;
   logic rx_line = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic dc_filter_enable, mod_2fsk, mod_gfsk, mod_ask, mod_msk, mod_unassigned;
   logic tx_take, tx_line, rx_data, rx_valid, rx_code_error;
   int failures = 0;
   int check_count = 0;
   int n;
   logic [2:0] code;
   logic [7:0] val;
   logic [0:2] half_a = 3'h4;
   logic [0:2] half_b = 3'h1;
   logic [0:2] tx_bits = 3'h5;
   modem_rate_format_config DUT (.clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .dc_filter_enable(dc_filter_enable), .mod_2fsk(mod_2fsk),
      .mod_gfsk(mod_gfsk), .mod_ask(mod_ask), .mod_msk(mod_msk),
      .mod_unassigned(mod_unassigned), .tx_data(tx_data), .tx_take(tx_take),
      .tx_line(tx_line), .rx_line(rx_line), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_code_error(rx_code_error));
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_sys);
      reg_addr = addr;
      reg_wdata = data;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
      @(negedge clk_sys);
      reg_addr = addr;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk("read valid", 8'h01, {7'h00, reg_rvalid});
      chk(name, exp, reg_rdata);
   endtask
   task automatic wait_take(output int cycles);
      cycles = 0;
      do begin
         @(negedge clk_sys);
         cycles++;
      end while (tx_take !== 1'b1 && cycles < 400);
      if (tx_take !== 1'b1) begin
         failures++;
         $display("mismatch tx_take wait expected 1 seen timeout");
         report_and_stop();
      end
   endtask
   task automatic period(input logic [7:0] expo, input int exp);
      wr(modem_cfg_pkg::ADDR_BW_RATE, expo);
      wait_take(n);
      wait_take(n);
      chk("tick period", exp[7:0], n[7:0]);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(negedge clk_sys);
      srst = 1'b0;
      rd(modem_cfg_pkg::ADDR_MANTISSA, 8'h22, "mantissa reset");
      rd(modem_cfg_pkg::ADDR_BW_RATE, 8'h8C, "exponent reset");
      rd(modem_cfg_pkg::ADDR_FORMAT, 8'h00, "format reset");
      chk("reset decode", 8'h30, {2'h0, dc_filter_enable, mod_2fsk, 4'h0});
      wr(modem_cfg_pkg::ADDR_MANTISSA, 8'hA5);
      wr(modem_cfg_pkg::ADDR_BW_RATE, 8'h3F);
      rd(modem_cfg_pkg::ADDR_MANTISSA, 8'hA5, "mantissa write");
      rd(modem_cfg_pkg::ADDR_BW_RATE, 8'h3F, "exponent write");
      ce = 1'b0;
      wr(modem_cfg_pkg::ADDR_MANTISSA, 8'h5A);
      ce = 1'b1;
      rd(modem_cfg_pkg::ADDR_MANTISSA, 8'hA5, "frozen write");
      wr(8'h13, 8'hFF);
      rd(8'h13, 8'h00, "unmapped read");
      rd(modem_cfg_pkg::ADDR_MANTISSA, 8'hA5, "unmapped write");
      wr(modem_cfg_pkg::ADDR_BW_RATE, 8'h8C);
      for (int c = 0; c < 8; c++) begin
         code = c[2:0];
         val = {code[0], code, 4'h7};
         wr(modem_cfg_pkg::ADDR_FORMAT, val);
         rd(modem_cfg_pkg::ADDR_FORMAT, val & 8'hF8, "format readback");
         chk("format decode", {2'h0, ~code[0], code == 3'h0, code == 3'h1, code == 3'h3,
            code == 3'h7, !(code inside {3'h0, 3'h1, 3'h3, 3'h7})},
            {2'h0, dc_filter_enable, mod_2fsk, mod_gfsk, mod_ask, mod_msk,
            mod_unassigned});
      end
      wr(modem_cfg_pkg::ADDR_FORMAT, 8'h00);
      wr(modem_cfg_pkg::ADDR_MANTISSA, 8'h00);
      period(8'h0F, 32);
      period(8'h0D, 128);
      period(8'h0F, 32);
      wr(modem_cfg_pkg::ADDR_FORMAT, 8'h08);
      rx_line = half_a[0];
      tx_data = tx_bits[0];
      wait_take(n);
      wait_take(n);
      chk("coded period", 8'h40, n[7:0]);
      for (int i = 0; i < 3; i++) begin
         @(negedge clk_sys);
         rx_line = half_b[i];
         repeat (10) @(negedge clk_sys);
         chk("tx first half", {7'h00, tx_bits[i]}, {7'h00, tx_line});
         n = 0;
         while (rx_valid !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
         end
         chk("rx valid", 8'h01, {7'h00, rx_valid});
         if (rx_valid !== 1'b1) begin
            report_and_stop();
         end
         chk("rx data", {7'h00, half_a[i]}, {7'h00, rx_data});
         chk("rx error", {7'h00, half_a[i] == half_b[i]}, {7'h00, rx_code_error});
         chk("tx second half", {7'h00, ~tx_bits[i]}, {7'h00, tx_line});
         if (i < 2) begin
            rx_line = half_a[i + 1];
            tx_data = tx_bits[i + 1];
            wait_take(n);
         end
      end
      report_and_stop();
   end
endmodule // modem_rate_format_config_tb
